// file: src/dll_lock_monitor.sv
/*
  Delay-locked-loop lock and reset tracking on the system clock.
  Assumes master_clock is asynchronous to clk_sys and is sampled here
  through two flip-flops; lock is counted in master clock rising edges.
*/
`timescale 1ns/1ps
`include "tap_port_regs.svh"

module dll_lock_monitor #(
  parameter int unsigned LOCK_CYCLES = `LOCK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic master_clock,
  output logic dll_locked
);
  import tap_port_pkg::*;

  localparam logic [1:0] KRESET_CYC = 2'(`KRESET_CYC);
  localparam logic [`LOCK_CNT_WIDTH-1:0] LOCK_LAST = `LOCK_CNT_WIDTH'(LOCK_CYCLES - 1);

  logic mclk_meta;
  logic mclk_sync;
  logic mclk_prev;
  logic [1:0] static_cnt;
  logic [`LOCK_CNT_WIDTH-1:0] lock_cnt;

  wire mclk_rise = mclk_sync & ~mclk_prev;
  wire mclk_still = (mclk_sync == mclk_prev);
  // two still sample intervals span 50 ns, the first count that surely covers 30 ns
  wire dll_reset = mclk_still && (static_cnt >= KRESET_CYC - 2'h1);
  wire lock_done = mclk_rise && (lock_cnt == LOCK_LAST);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mclk_meta <= 1'b0;
      mclk_sync <= 1'b0;
      mclk_prev <= 1'b0;
    end
    else
    begin
      mclk_meta <= master_clock;
      mclk_sync <= mclk_meta;
      mclk_prev <= mclk_sync;
    end
  end

  // counts whole cycles without an edge; saturates to hold the reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      static_cnt <= 2'h0;
    else if (!mclk_still)
      static_cnt <= 2'h0;
    else if (static_cnt < KRESET_CYC)
      static_cnt <= static_cnt + 2'h1;
  end

  // a fresh lock interval starts after every static reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_cnt <= '0;
      dll_locked <= 1'b0;
    end
    else if (dll_reset)
    begin
      lock_cnt <= '0;
      dll_locked <= 1'b0;
    end
    else if (lock_done)
      dll_locked <= 1'b1;
    else if (mclk_rise && !dll_locked)
      lock_cnt <= lock_cnt + `LOCK_CNT_WIDTH'(1);
  end

  //////////////////////////////////////////////////////////////////////////
  static_unlock_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    dll_reset |=> !dll_locked && lock_cnt == '0)
    else $error("static master clock did not drop lock");

  lock_wait_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(dll_locked) |-> $past(lock_cnt) == LOCK_LAST)
    else $error("lock declared before the full edge count");

endmodule

// file: src/sram_boundary_scan_tap_port.sv
/*
  Test access port of the burst SRAM: instruction register, bypass,
  identification and boundary-scan data registers, serial output on the
  falling test clock edge, and the delay-locked-loop lock tracker.
  Assumes tck from the external test controller, pin_sample from the I/O
  ring (asynchronous to tck), and master_clock asynchronous to clk_sys.

  // Summary of operation
  // - The controller changes state only on test clock edges.
  // - Mode select is sampled on each rising test clock edge to steer the controller.
  // - Serial input enters the selected register one bit per rising test clock edge.
  // - Serial output is updated from the selected register on the falling test clock edge.
  // - There is one instruction register and several selectable data registers.
  // - Only the external-test and floated-sample instructions disturb memory operation.
  // - A master clock static for 30 ns resets the loop, and a new lock interval must pass.
  // - Power up or five rising edges with mode select high put the controller in reset.
  // - Input is taken and the output driven only in the two shift states.
  // - The 3-bit instruction loads 001 at power up, in reset and in capture, and acts at update.
*/
`timescale 1ns/1ps
`include "tap_port_regs.svh"

module sram_boundary_scan_tap_port #(
  parameter int unsigned LOCK_CYCLES = `LOCK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic master_clock,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [`BSR_WIDTH-1:0] pin_sample,
  output logic tdo_out,
  output logic tdo_oe,
  output logic [`BSR_WIDTH-1:0] pin_drive,
  output logic pin_drive_en,
  output logic q_float,
  output logic odt_off,
  output logic memory_disrupt,
  output logic dll_locked
);
  import tap_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // controller

  tap_state_type state;
  tap_ctrl_type ctrl;

  tap_state_machine u_fsm (
    .tck(tck),
    .rst_b(rst_b),
    .tms(tms),
    .state(state),
    .ctrl(ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // instruction register

  logic [`IR_WIDTH-1:0] ir_shift;
  logic [`IR_WIDTH-1:0] ir;
  instr_flags_type flags;
  instr_flags_type next_flags;

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      ir_shift <= `IR_IDCODE;
    else if (ctrl.reset || ctrl.capture_ir)
      ir_shift <= `IR_IDCODE;
    else if (ctrl.shift_ir)
      ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]};
  end

  // the live instruction changes only at update or in reset, so shifting is harmless
  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      ir <= `IR_IDCODE;
    else if (ctrl.reset)
      ir <= `IR_IDCODE;
    else if (ctrl.update_ir)
      ir <= ir_shift;
  end

  wire [`IR_WIDTH-1:0] next_ir = ctrl.reset ? `IR_IDCODE :
                                 ctrl.update_ir ? ir_shift : ir;
  wire is_extest = (next_ir == `IR_EXTEST);
  wire is_sample_z = (next_ir == `IR_SAMPLE_Z);
  wire is_sample = (next_ir == `IR_SAMPLE);

  assign next_flags.extest = is_extest;
  assign next_flags.sample_z = is_sample_z;
  assign next_flags.bsr_sel = is_extest | is_sample_z | is_sample;
  assign next_flags.id_sel = (next_ir == `IR_IDCODE);

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      flags <= '{extest: 1'b0, sample_z: 1'b0, bsr_sel: 1'b0, id_sel: 1'b1};
    else
      flags <= next_flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin capture: the ring is asynchronous to tck

  logic [`BSR_WIDTH-1:0] pin_meta;
  logic [`BSR_WIDTH-1:0] pin_sync;

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta <= `BSR_RESET;
      pin_sync <= `BSR_RESET;
    end
    else
    begin
      pin_meta <= pin_sample;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers; private code falls back to bypass

  logic bypass;
  logic [`ID_WIDTH-1:0] id_reg;
  logic [`BSR_WIDTH-1:0] bsr;

  wire sel_bypass = !flags.id_sel && !flags.bsr_sel;

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      bypass <= 1'b0;
    else if (ctrl.capture_dr && sel_bypass)
      bypass <= 1'b0;
    else if (ctrl.shift_dr && sel_bypass)
      bypass <= tdi;
  end

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      id_reg <= `ID_VALUE;
    else if (ctrl.capture_dr && flags.id_sel)
      id_reg <= `ID_VALUE;
    else if (ctrl.shift_dr && flags.id_sel)
      id_reg <= {tdi, id_reg[`ID_WIDTH-1:1]};
  end

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      bsr <= `BSR_RESET;
    else if (ctrl.capture_dr && flags.bsr_sel)
      bsr <= pin_sync;
    else if (ctrl.shift_dr && flags.bsr_sel)
      bsr <= {tdi, bsr[`BSR_WIDTH-1:1]};
  end

  // pins follow only at update, never during the shift
  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      pin_drive <= `BSR_RESET;
    else if (ctrl.update_dr && flags.bsr_sel)
      pin_drive <= bsr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction side effects; only two codes touch the memory

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_drive_en <= 1'b0;
      q_float <= 1'b0;
      odt_off <= 1'b0;
    end
    else
    begin
      pin_drive_en <= next_flags.extest;
      q_float <= next_flags.sample_z;
      odt_off <= next_flags.extest | next_flags.sample_z;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output, moved on the falling edge half a period after sampling

  wire serial_src = ctrl.shift_ir ? ir_shift[0] :
                    flags.bsr_sel ? bsr[0] :
                    flags.id_sel ? id_reg[0] : bypass;
  wire shifting = ctrl.shift_ir | ctrl.shift_dr;

  always_ff @(negedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo_out <= shifting ? serial_src : 1'b0;
      tdo_oe <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // disruption level crosses into clk_sys through two flip-flops

  logic disrupt_meta;
  logic disrupt_sync;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      disrupt_meta <= 1'b0;
      disrupt_sync <= 1'b0;
    end
    else
    begin
      disrupt_meta <= odt_off;
      disrupt_sync <= disrupt_meta;
    end
  end

  assign memory_disrupt = disrupt_sync;

  ////////////////////////////////////////////////////////////////////////////
  // loop lock tracking on the system clock

  dll_lock_monitor #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_dll (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .master_clock(master_clock),
    .dll_locked(dll_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  ir_reset_load_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    ctrl.reset |=> (ir == `IR_IDCODE) && flags.id_sel)
    else $error("reset did not load the identification code");

  ir_capture_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    ctrl.capture_ir |=> (ir_shift == `IR_IDCODE) && $stable(ir))
    else $error("instruction capture wrong or live code moved");

  ir_update_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    ctrl.update_ir |=> ir == $past(ir_shift))
    else $error("update did not take the shifted instruction");

  bypass_shift_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (ctrl.shift_dr && sel_bypass) |=> bypass == $past(tdi))
    else $error("bypass did not take the input bit");

  tdo_value_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (shifting && $past(shifting)) |-> tdo_oe && tdo_out == serial_src)
    else $error("serial output not updated from the selected register");

  tdo_enable_a: assert property (
    @(negedge tck) disable iff (!rst_b)
    !shifting |=> !tdo_oe)
    else $error("serial output driven outside shift");

  quiet_memory_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (ir != `IR_EXTEST && ir != `IR_SAMPLE_Z) |-> !pin_drive_en && !q_float && !odt_off)
    else $error("memory disturbed by a harmless instruction");

  disrupt_cross_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (odt_off) [*3] |-> memory_disrupt)
    else $error("disruption level not passed to the memory side");

  disrupt_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (!odt_off) [*3] |-> !memory_disrupt)
    else $error("disruption level stuck on the memory side");

  id_capture_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (ctrl.capture_dr && flags.id_sel) |=> id_reg == `ID_VALUE)
    else $error("identification register not loaded at capture");

endmodule

// file: src/tap_port_pkg.sv
/*
  Types shared by the test access port files: controller states and the
  decoded controller phases passed from the state machine to the datapath.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tap_port_pkg;

  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr,
    st_ex2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir,
    st_pa_ir, st_ex2_ir, st_upd_ir
  } tap_state_type;

  typedef struct packed {
    logic reset;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } tap_ctrl_type;

  typedef struct packed {
    logic extest;
    logic sample_z;
    logic bsr_sel;
    logic id_sel;
  } instr_flags_type;

endpackage

// file: src/tap_port_regs.svh
/*
  Constants of the SRAM test access port: instruction codes, register
  widths, identification value and delay-locked-loop timing figures.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef TAP_PORT_REGS_SVH
`define TAP_PORT_REGS_SVH

`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_PRIVATE 3'h3
`define IR_SAMPLE 3'h4

`define ID_WIDTH 32
// arbitrary value, bit 0 set as an identification register requires
`define ID_VALUE 32'h0A5C_3E71
`define BSR_WIDTH 8
`define BSR_RESET 8'h00

`define CLK_SYS_NS 25
`define KRESET_NS 30
`define KRESET_CYC ((`KRESET_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define LOCK_CYCLES 65536
`define LOCK_CNT_WIDTH 17
`define TMS_RESET_EDGES 5

`endif

// file: src/tap_state_machine.sv
/*
  Sixteen-state test controller, clocked only by the test clock.
  Assumes tms is stable around each rising tck edge and rst_b is the
  power-up reset.
*/
`timescale 1ns/1ps
`include "tap_port_regs.svh"

module tap_state_machine (
  input wire logic tck,
  input wire logic rst_b,
  input wire logic tms,
  output tap_port_pkg::tap_state_type state,
  output tap_port_pkg::tap_ctrl_type ctrl
);
  import tap_port_pkg::*;

  tap_state_type next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      st_reset: next_state = tms ? st_reset : st_idle;
      st_idle: next_state = tms ? st_sel_dr : st_idle;
      st_sel_dr: next_state = tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: next_state = tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr: next_state = tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: next_state = tms ? st_upd_dr : st_pa_dr;
      st_pa_dr: next_state = tms ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: next_state = tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: next_state = tms ? st_sel_dr : st_idle;
      st_sel_ir: next_state = tms ? st_reset : st_cap_ir;
      st_cap_ir: next_state = tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir: next_state = tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: next_state = tms ? st_upd_ir : st_pa_ir;
      st_pa_ir: next_state = tms ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: next_state = tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: next_state = tms ? st_sel_dr : st_idle;
      default: next_state = st_reset;
    endcase
  end

  // moves only on tck, never on the memory clock
  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
      state <= st_reset;
    else
      state <= next_state;
  end

  assign ctrl.reset = (state == st_reset);
  assign ctrl.capture_ir = (state == st_cap_ir);
  assign ctrl.shift_ir = (state == st_sh_ir);
  assign ctrl.update_ir = (state == st_upd_ir);
  assign ctrl.capture_dr = (state == st_cap_dr);
  assign ctrl.shift_dr = (state == st_sh_dr);
  assign ctrl.update_dr = (state == st_upd_dr);

  //////////////////////////////////////////////////////////////////////////
  tms_reset_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (tms [*5]) |=> (state == st_reset))
    else $error("five tms highs did not reach reset");

  tms_steer_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    (state == st_reset && !tms) |=> (state == st_idle) ##0 $past(state) == st_reset)
    else $error("tms low in reset did not reach idle");

endmodule

// file: verif/jtag_ctrl_model.sv
/*
  Behavioural model of the external test controller on the link: makes
  the test clock only inside frames, drives mode select and serial data
  while the clock is low, and records the serial output.
  Assumes the bench calls step() once per test clock period.
*/
`timescale 1ns/1ps

module jtag_ctrl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  logic last_q;
  logic last_oe;
  logic held_q;
  int tdo_moved;

  initial
  begin
    // clock parked low, select and data at their pulled-up level
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_q = 1'b0;
    last_oe = 1'b0;
    held_q = 1'b0;
    tdo_moved = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one 160 ns period; inputs change only while the clock is low
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #70;
    held_q = tdo_out;
    tck = 1'b1;
    #1;
    // serial output must not move on the rising edge
    if (tdo_out !== held_q)
    begin
      tdo_moved++;
    end
    #79;
    tck = 1'b0;
    #10;
    // undriven pin carries no data: flip the last value so a stray read shows
    last_q = tdo_oe ? tdo_out : ~last_q;
    last_oe = tdo_oe;
  endtask
endmodule

// file: verif/testbench.sv
/*
  Self-checking bench of the SRAM test access port: link traffic through
  the controller model, master clock and I/O samples from the bench.
  Assumes the design and model files are compiled before it.
*/
`timescale 1ns/1ps
`include "tap_port_regs.svh"

module testbench;
  logic clk_sys, rst_b, master_clock, mck_run;
  logic tck, tms, tdi, tdo_out, tdo_oe;
  logic [`BSR_WIDTH-1:0] pin_sample, pin_drive;
  logic pin_drive_en, q_float, odt_off, memory_disrupt, dll_locked;
  logic [31:0] d;
  int n_fail, tests_run, cycles;

  sram_boundary_scan_tap_port #(.LOCK_CYCLES(16)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .master_clock(master_clock), .tck(tck),
    .tms(tms), .tdi(tdi), .pin_sample(pin_sample), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe), .pin_drive(pin_drive), .pin_drive_en(pin_drive_en),
    .q_float(q_float), .odt_off(odt_off), .memory_disrupt(memory_disrupt),
    .dll_locked(dll_locked));

  jtag_ctrl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // master clock at half the system rate: 25 ns phases stay under the static reset time
  always @(negedge clk_sys)
  begin
    if (mck_run)
    begin
      master_clock <= ~master_clock;
    end
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // entered in a shift state; tms goes high with the last bit
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      dout[i] = u_ctl.last_q;
      check(u_ctl.last_oe, 1'b1, "output enable in shift");
      u_ctl.step(i == n - 1, din[i]);
    end
    check(u_ctl.last_oe, 1'b0, "output enable after shift");
  endtask

  task automatic to_shift_dr();
    u_ctl.step(1'b1, 1'b1);
    u_ctl.step(1'b0, 1'b1);
    u_ctl.step(1'b0, 1'b1);
  endtask

  task automatic to_shift_ir();
    u_ctl.step(1'b1, 1'b1);
    to_shift_dr();
  endtask

  task automatic to_idle();
    u_ctl.step(1'b1, 1'b1);
    u_ctl.step(1'b0, 1'b1);
  endtask

  task automatic load_ir(input logic [2:0] code);
    to_shift_ir();
    shift(3, {29'd0, code}, d);
    check(d, 32'h0000_0001, "captured instruction");
    to_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({tdo_oe, pin_drive_en, q_float, odt_off}, 4'h0, "flags at reset");
    check({memory_disrupt, dll_locked}, 2'h0, "system flags at reset");
    u_ctl.step(1'b0, 1'b1);
  endtask

  // identification read with the master clock frozen
  task automatic t_id();
    to_shift_dr();
    shift(32, 32'h5A5A_0F0F, d);
    check(d, `ID_VALUE, "identification shifted out");
    to_idle();
  endtask

  task automatic t_instr();
    logic [2:0] codes [6];
    logic ext, flt;
    codes = '{`IR_EXTEST, `IR_IDCODE, `IR_SAMPLE_Z, `IR_PRIVATE, `IR_SAMPLE, 3'h7};
    foreach (codes[k])
    begin
      load_ir(codes[k]);
      ext = (codes[k] == `IR_EXTEST);
      flt = (codes[k] == `IR_SAMPLE_Z);
      check({pin_drive_en, q_float, odt_off}, {ext, flt, ext | flt}, "instr flags");
      repeat (4) @(negedge clk_sys);
      check(memory_disrupt, ext | flt, "memory disrupt");
    end
  endtask

  task automatic t_bsr();
    @(negedge clk_sys);
    pin_sample = 8'hA3;
    load_ir(`IR_SAMPLE);
    to_shift_dr();
    shift(`BSR_WIDTH, 32'h0000_006C, d);
    check(d, 32'h0000_00A3, "boundary capture");
    to_idle();
    check(pin_drive, 8'h6C, "boundary update");
    to_shift_ir();
    shift(3, {29'd0, `IR_EXTEST}, d);
    // instruction shifted in but not yet updated
    check(pin_drive_en, 1'b0, "early instruction effect");
    to_idle();
    check({pin_drive_en, pin_drive}, 9'h16C, "external test live");
  endtask

  task automatic t_bypass();
    load_ir(`IR_PRIVATE);
    to_shift_dr();
    shift(2, 32'h0000_0001, d);
    check(d[0], 1'b0, "bypass captured zero");
    check(d[1], 1'b1, "one-bit bypass");
    to_idle();
  endtask

  // extest made live here, then dropped by mode select alone
  task automatic t_tms_reset();
    load_ir(`IR_EXTEST);
    to_shift_dr();
    repeat (4) u_ctl.step(1'b1, 1'b1);
    check(pin_drive_en, 1'b1, "four ones too few");
    repeat (2) u_ctl.step(1'b1, 1'b1);
    check({pin_drive_en, odt_off}, 2'h0, "reset by mode select");
    u_ctl.step(1'b0, 1'b1);
  endtask

  task automatic t_dll();
    int w;
    mck_run = 1'b1;
    repeat (20) @(negedge clk_sys);
    check(dll_locked, 1'b0, "locked too early");
    for (w = 0; w < 100 && dll_locked !== 1'b1; w++) @(negedge clk_sys);
    check(dll_locked, 1'b1, "lock after count");
    mck_run = 1'b0;
    repeat (10) @(negedge clk_sys);
    check(dll_locked, 1'b0, "static clock reset");
    mck_run = 1'b1;
    repeat (20) @(negedge clk_sys);
    check(dll_locked, 1'b0, "relock too early");
    for (w = 0; w < 100 && dll_locked !== 1'b1; w++) @(negedge clk_sys);
    check(dll_locked, 1'b1, "relock after count");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    master_clock = 1'b0;
    mck_run = 1'b0;
    pin_sample = 8'h5C;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_id();
    t_instr();
    t_bsr();
    t_bypass();
    t_tms_reset();
    t_dll();
    check(u_ctl.tdo_moved, 0, "output moved on rising edge");
    stop_test();
  end
endmodule
